// ==== rtl/nvm_prog_pkg.sv ====
// constants and types for the parallel programming port
//
// Summary of operation
// - three signature bytes at addresses 0 to 2
// - calibration byte at high byte of address 0
// - reset copies calibration byte into oscillator trim
// - flash: 256 pages of 64 words
// - eeprom: pages of four bytes
// - ready/busy low while an operation runs
// - data bus driven only while output enable low
// - write or output-enable strobe runs loaded command
// - byte select: 0 low byte, 1 high
// - extended select: 0 low, 1 second high byte
// - page-load pulse latches data into page buffer
// - load strobe: address, data, command or idle
// - decode chip erase, fuse and lock writes
// - decode flash write and eeprom write
// - decode signature, flash and eeprom reads
// - decode fuse and lock read-back
// - high-voltage removal or power-down leaves programming mode
// - command and address retained across operations
// - chip erase starts on write strobe, busy
// - no-operation command ends page programming session
`default_nettype none
package nvm_prog_pkg;
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [3:0] ENTRY_PATTERN = 4'h0;
    // signature and calibration values are arbitrary
    localparam logic [7:0] SIG_BYTE0 = 8'h5a;
    localparam logic [7:0] SIG_BYTE1 = 8'h3c;
    localparam logic [7:0] SIG_BYTE2 = 8'h01;
    localparam logic [7:0] CAL_BYTE = 8'h80;
    localparam logic [1:0] SIG_ADDR0 = 2'h0;
    localparam logic [1:0] SIG_ADDR1 = 2'h1;
    localparam logic [7:0] FUSE_LOW_RST = 8'h62;
    localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
    localparam logic [7:0] FUSE_EXT_RST = 8'hff;
    localparam logic [7:0] LOCK_ERASED = 8'hff;
    localparam int KEEP_EE_BIT = 3;
    localparam int FLASH_ADDR_TOP_BIT = 13;
    localparam int EEPROM_ADDR_TOP_BIT = 13;
    localparam int FLASH_PAGE_LSB = 6;
    localparam int EE_PAGE_LSB = 2;
    localparam int FLASH_WORDS = 64;
    localparam logic [5:0] FLASH_LAST = 6'h3f;
    localparam logic [5:0] EE_LAST = 6'h03;
    localparam logic [15:0] WRITE_CYCLES_DEF = 16'h0040;
    localparam logic [15:0] ERASE_CYCLES_DEF = 16'h0100;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PROG = 4'h2,
        ST_WAIT = 4'h4,
        ST_ERASE = 4'h8
    } state_t;
    typedef struct packed {
        logic hv;
        logic ld;
        logic wr_n;
        logic oe_n;
        logic bs1;
        logic bs2;
        logic xa1;
        logic xa0;
        logic page_buffer_latch;
        logic [7:0] data;
    } pins_t;
    localparam pins_t PINS_IDLE = '{hv: 1'b0, ld: 1'b0, wr_n: 1'b1, oe_n: 1'b1, bs1: 1'b0,
        bs2: 1'b0, xa1: 1'b0, xa0: 1'b0, page_buffer_latch: 1'b0, data: 8'h00};
endpackage : nvm_prog_pkg
`default_nettype wire

// ==== rtl/parallel_nvm_programming_port.sv ====
// device side of the high-voltage parallel programming port
`default_nettype none
module parallel_nvm_programming_port #(
    parameter logic [15:0] WRITE_CYCLES = nvm_prog_pkg::WRITE_CYCLES_DEF,
    parameter logic [15:0] ERASE_CYCLES = nvm_prog_pkg::ERASE_CYCLES_DEF
) (
    input wire logic core_clk_i, // 125 MHz core clock
    input wire logic rstn_i, // power reset, active low
    input wire logic hv_reset_i, // high voltage seen on reset pin
    input wire logic load_strobe_i, // load strobe pin
    input wire logic wr_n_i, // write strobe, active low
    input wire logic oe_n_i, // output enable, active low
    input wire logic byte_select_lo_hi_i, // byte select 1
    input wire logic byte_select_ext_i, // byte select 2
    input wire logic strobe_action_bit0_i, // action select bit 0
    input wire logic strobe_action_bit1_i, // action select bit 1
    input wire logic page_buffer_latch_i, // page load pin
    input wire logic [7:0] data_i, // data bus input
    input wire logic [15:0] nvm_rdata_i, // array read data at nvm_addr_o
    output logic [7:0] data_o, // data bus output
    output logic data_oe_n_o, // data bus drive, low drives
    output logic ready_busy_n_o, // high ready, low busy
    output logic prog_mode_o, // in parallel programming mode
    output logic [7:0] osc_trim_register_o, // oscillator trim
    output logic [7:0] fuse_ext_o, // extended fuse byte
    output logic [7:0] fuse_high_o, // fuse high byte
    output logic [7:0] fuse_low_o, // fuse low byte
    output logic [7:0] lock_o, // lock bits
    output logic nvm_we_o, // array write pulse
    output logic nvm_ee_o, // array target is eeprom
    output logic [13:0] nvm_addr_o, // array address
    output logic [15:0] nvm_wdata_o, // array write data
    output logic nvm_erase_o, // flash erase pulse
    output logic nvm_erase_ee_o // eeprom erase pulse
);
    function automatic logic [7:0] hi_lo(input logic sel, input logic [15:0] w);
        hi_lo = sel ? w[15:8] : w[7:0];
    endfunction : hi_lo

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    nvm_prog_pkg::pins_t pin_meta;
    nvm_prog_pkg::pins_t pin;
    nvm_prog_pkg::pins_t pin_prev;
    nvm_prog_pkg::pins_t pin_raw;
    assign pin_raw = '{hv: hv_reset_i, ld: load_strobe_i, wr_n: wr_n_i, oe_n: oe_n_i,
        bs1: byte_select_lo_hi_i, bs2: byte_select_ext_i, xa1: strobe_action_bit1_i,
        xa0: strobe_action_bit0_i, page_buffer_latch: page_buffer_latch_i, data: data_i};
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_meta <= nvm_prog_pkg::PINS_IDLE;
            pin <= nvm_prog_pkg::PINS_IDLE;
            pin_prev <= nvm_prog_pkg::PINS_IDLE;
        end else begin
            pin_meta <= pin_raw;
            pin <= pin_meta;
            pin_prev <= pin;
        end
    end

    nvm_prog_pkg::state_t state;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] dat_lo;
    logic [7:0] dat_hi;
    logic session;
    logic [5:0] idx;
    logic [15:0] cnt;
    logic [15:0] flash_buf [nvm_prog_pkg::FLASH_WORDS];
    logic [7:0] ee_buf [4];

    wire logic idle = state == nvm_prog_pkg::ST_IDLE;
    wire logic [1:0] act = {pin.xa1, pin.xa0};
    wire logic [3:0] entry = {pin.page_buffer_latch, pin.xa1, pin.xa0, pin.bs1};
    wire logic ld_ok = prog_mode_o & idle & pin.ld & ~pin_prev.ld;
    wire logic wr_ok = prog_mode_o & idle & ~pin.wr_n & pin_prev.wr_n;
    wire logic pg_ok = prog_mode_o & idle & pin.page_buffer_latch & ~pin_prev.page_buffer_latch;
    wire logic hv_rise = pin.hv & ~pin_prev.hv;
    wire logic [15:0] addr = {addr_hi, addr_lo};
    wire logic [15:0] dat = {dat_hi, dat_lo};
    wire logic is_ee = cmd == nvm_prog_pkg::CMD_WR_EE;
    wire logic is_flash = cmd == nvm_prog_pkg::CMD_WR_FLASH;
    wire logic [5:0] last_idx = is_ee ? nvm_prog_pkg::EE_LAST : nvm_prog_pkg::FLASH_LAST;
    wire logic keep_eeprom_on_erase = ~fuse_high_o[nvm_prog_pkg::KEEP_EE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // mode entry and exit
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prog_mode_o <= 1'b0;
        end else if (!pin.hv) begin
            prog_mode_o <= 1'b0;
        end else if (hv_rise) begin
            prog_mode_o <= entry == nvm_prog_pkg::ENTRY_PATTERN;
        end
    end

    // trim is loaded with the stored calibration byte on every reset
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_trim_register_o <= nvm_prog_pkg::CAL_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // load strobe: command, address and data latches, retained across operations
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd <= nvm_prog_pkg::CMD_NOP;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            dat_lo <= 8'h00;
            dat_hi <= 8'h00;
        end else if (ld_ok) begin
            case (act)
                nvm_prog_pkg::ACT_ADDR: begin
                    if (pin.bs1) begin
                        addr_hi <= pin.data;
                    end else begin
                        addr_lo <= pin.data;
                    end
                end
                nvm_prog_pkg::ACT_DATA: begin
                    if (pin.bs1) begin
                        dat_hi <= pin.data;
                    end else begin
                        dat_lo <= pin.data;
                    end
                end
                nvm_prog_pkg::ACT_CMD: begin
                    cmd <= pin.data;
                end
                default: begin
                end
            endcase
        end
    end

    // page session opens with a page latch and closes with a no-operation command
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            session <= 1'b0;
        end else if (!prog_mode_o) begin
            session <= 1'b0;
        end else if (ld_ok && act == nvm_prog_pkg::ACT_CMD && pin.data == nvm_prog_pkg::CMD_NOP) begin
            session <= 1'b0;
        end else if (pg_ok && (is_flash || is_ee)) begin
            session <= 1'b1;
        end
    end

    // page buffers are plain storage without reset
    always_ff @(posedge core_clk_i) begin
        if (pg_ok && is_flash) begin
            flash_buf[addr_lo[nvm_prog_pkg::FLASH_PAGE_LSB-1:0]] <= dat;
        end
        if (pg_ok && is_ee) begin
            ee_buf[addr_lo[nvm_prog_pkg::EE_PAGE_LSB-1:0]] <= dat_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operation sequencer and nonvolatile bits
    wire logic start_page = wr_ok & (is_flash | is_ee) & session;
    wire logic start_erase = wr_ok & (cmd == nvm_prog_pkg::CMD_ERASE);
    wire logic wr_fuse = wr_ok & (cmd == nvm_prog_pkg::CMD_WR_FUSE);
    wire logic wr_lock = wr_ok & (cmd == nvm_prog_pkg::CMD_WR_LOCK);
    wire logic [13:0] flash_str = {addr[nvm_prog_pkg::FLASH_ADDR_TOP_BIT:nvm_prog_pkg::FLASH_PAGE_LSB], idx};
    wire logic [13:0] ee_str = {addr[nvm_prog_pkg::EEPROM_ADDR_TOP_BIT:nvm_prog_pkg::EE_PAGE_LSB], idx[1:0]};

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= nvm_prog_pkg::ST_IDLE;
            ready_busy_n_o <= 1'b1;
            idx <= 6'h00;
            cnt <= 16'h0000;
        end else begin
            case (state)
                nvm_prog_pkg::ST_IDLE: begin
                    idx <= 6'h00;
                    if (start_page) begin
                        state <= nvm_prog_pkg::ST_PROG;
                        ready_busy_n_o <= 1'b0;
                    end else if (start_erase) begin
                        state <= nvm_prog_pkg::ST_ERASE;
                        ready_busy_n_o <= 1'b0;
                        cnt <= ERASE_CYCLES;
                    end else if (wr_fuse || wr_lock) begin
                        state <= nvm_prog_pkg::ST_WAIT;
                        ready_busy_n_o <= 1'b0;
                        cnt <= WRITE_CYCLES;
                    end
                end
                nvm_prog_pkg::ST_PROG: begin
                    idx <= idx + 6'h01;
                    if (idx == last_idx) begin
                        state <= nvm_prog_pkg::ST_WAIT;
                        cnt <= WRITE_CYCLES;
                    end
                end
                nvm_prog_pkg::ST_WAIT, nvm_prog_pkg::ST_ERASE: begin
                    cnt <= cnt - 16'h0001;
                    if (cnt == 16'h0000) begin
                        state <= nvm_prog_pkg::ST_IDLE;
                        ready_busy_n_o <= 1'b1;
                    end
                end
                default: begin
                    state <= nvm_prog_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // array port driven from the sequencer; at rest it shows the read address
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nvm_we_o <= 1'b0;
            nvm_ee_o <= 1'b0;
            nvm_addr_o <= 14'h0000;
            nvm_wdata_o <= 16'h0000;
            nvm_erase_o <= 1'b0;
            nvm_erase_ee_o <= 1'b0;
        end else begin
            nvm_we_o <= state == nvm_prog_pkg::ST_PROG;
            nvm_ee_o <= is_ee | (cmd == nvm_prog_pkg::CMD_RD_EE);
            nvm_addr_o <= state != nvm_prog_pkg::ST_PROG ? addr[13:0] : (is_ee ? ee_str : flash_str);
            nvm_wdata_o <= is_ee ? {8'h00, ee_buf[idx[1:0]]} : flash_buf[idx];
            nvm_erase_o <= start_erase;
            nvm_erase_ee_o <= start_erase & ~keep_eeprom_on_erase;
        end
    end

    // fuses keep value over erase; lock bits clear only when the erase finishes
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fuse_low_o <= nvm_prog_pkg::FUSE_LOW_RST;
            fuse_high_o <= nvm_prog_pkg::FUSE_HIGH_RST;
            fuse_ext_o <= nvm_prog_pkg::FUSE_EXT_RST;
            lock_o <= nvm_prog_pkg::LOCK_ERASED;
        end else begin
            if (wr_fuse && pin.bs2) begin
                fuse_ext_o <= dat_lo;
            end else if (wr_fuse && pin.bs1) begin
                fuse_high_o <= dat_lo;
            end else if (wr_fuse) begin
                fuse_low_o <= dat_lo;
            end
            if (wr_lock) begin
                lock_o <= lock_o & dat_lo;
            end else if (state == nvm_prog_pkg::ST_ERASE && cnt == 16'h0000) begin
                lock_o <= nvm_prog_pkg::LOCK_ERASED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read-back selection; signature is readable whatever the lock bits say
    wire logic [7:0] sig_byte = addr_lo[1:0] == nvm_prog_pkg::SIG_ADDR0 ? nvm_prog_pkg::SIG_BYTE0 :
        addr_lo[1:0] == nvm_prog_pkg::SIG_ADDR1 ? nvm_prog_pkg::SIG_BYTE1 : nvm_prog_pkg::SIG_BYTE2;
    wire logic cal_sel = pin.bs1 & (addr_lo[1:0] == nvm_prog_pkg::SIG_ADDR0);
    wire logic [7:0] sig_rd = hi_lo(cal_sel, {nvm_prog_pkg::CAL_BYTE, sig_byte});
    wire logic [7:0] fuse_rd = pin.bs2 ? (pin.bs1 ? fuse_high_o : fuse_ext_o) :
        (pin.bs1 ? lock_o : fuse_low_o);
    wire logic [7:0] rd_data = cmd == nvm_prog_pkg::CMD_RD_SIG ? sig_rd :
        cmd == nvm_prog_pkg::CMD_RD_FUSE ? fuse_rd :
        cmd == nvm_prog_pkg::CMD_RD_FLASH ? hi_lo(pin.bs1, nvm_rdata_i) :
        cmd == nvm_prog_pkg::CMD_RD_EE ? nvm_rdata_i[7:0] : 8'h00;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_o <= 8'h00;
            data_oe_n_o <= 1'b1;
        end else begin
            data_o <= rd_data;
            data_oe_n_o <= ~(prog_mode_o & ~pin.oe_n);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    // length of the current array write burst
    logic [6:0] we_run;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            we_run <= 7'h00;
        end else begin
            we_run <= nvm_we_o ? we_run + 7'h01 : 7'h00;
        end
    end

    AST_ERASE_BUSY: assert property (start_erase |=> !ready_busy_n_o && nvm_erase_o)
        else $error("erase did not go busy");
    AST_PAGE_BUSY: assert property (nvm_we_o |-> !ready_busy_n_o)
        else $error("array written while ready");
    AST_BUS_RELEASE: assert property (pin.oe_n |=> data_oe_n_o)
        else $error("bus driven without output enable");
    AST_CMD_LOAD: assert property (ld_ok && act == nvm_prog_pkg::ACT_CMD |=> cmd == $past(pin.data))
        else $error("command not latched");
    AST_NOP_ENDS: assert property (ld_ok && act == nvm_prog_pkg::ACT_CMD && pin.data == 8'h00 |=> !session)
        else $error("session survived no-operation");
    AST_SIG1: assert property (cmd == nvm_prog_pkg::CMD_RD_SIG && addr_lo[1:0] == 2'h1 && !pin.bs1
        |=> data_o == nvm_prog_pkg::SIG_BYTE1)
        else $error("signature byte wrong");
    AST_CAL: assert property (cmd == nvm_prog_pkg::CMD_RD_SIG && addr_lo[1:0] == 2'h0 && pin.bs1
        |=> data_o == nvm_prog_pkg::CAL_BYTE)
        else $error("calibration byte wrong");
    AST_TRIM: assert property (osc_trim_register_o == nvm_prog_pkg::CAL_BYTE)
        else $error("trim differs from calibration");
    AST_FLASH_PAGE: assert property (nvm_we_o && !nvm_ee_o |-> nvm_addr_o[13:6] == addr[13:6])
        else $error("flash page address wrong");
    AST_EE_PAGE: assert property (nvm_we_o && nvm_ee_o |-> nvm_addr_o[13:2] == addr[13:2])
        else $error("eeprom page address wrong");
    AST_EXIT: assert property (!pin.hv |=> !prog_mode_o)
        else $error("mode kept without high voltage");
    AST_EE_LEN: assert property ($rose(nvm_we_o) && nvm_ee_o |-> nvm_we_o [*4] ##1 !nvm_we_o)
        else $error("eeprom page not four bytes");
    AST_FLASH_LEN: assert property (nvm_we_o && !nvm_ee_o |-> we_run < 7'(nvm_prog_pkg::FLASH_WORDS))
        else $error("flash burst too long");
    AST_FLASH_END: assert property ($fell(nvm_we_o) && !nvm_ee_o
        |-> we_run == 7'(nvm_prog_pkg::FLASH_WORDS))
        else $error("flash burst too short");
    AST_READY_IDLE: assert property (ready_busy_n_o == idle)
        else $error("ready level disagrees with sequencer");
    AST_FUSE_EXT: assert property (wr_fuse && pin.bs2 |=> fuse_ext_o == $past(dat_lo))
        else $error("extended fuse not written");
    AST_FUSE_HIGH: assert property (wr_fuse && !pin.bs2 && pin.bs1 |=> fuse_high_o == $past(dat_lo))
        else $error("high fuse not written");
    AST_ERASE_LOCK: assert property ($rose(ready_busy_n_o) && $past(state) == nvm_prog_pkg::ST_ERASE
        |-> lock_o == nvm_prog_pkg::LOCK_ERASED)
        else $error("lock bits not cleared by erase");

    COV_FLASH_PAGE: cover property (start_page && is_flash);
    COV_EE_PAGE: cover property (start_page && is_ee);
    COV_ERASE_DONE: cover property (state == nvm_prog_pkg::ST_ERASE ##1 ready_busy_n_o);
    COV_READ_DRIVE: cover property (!data_oe_n_o && cmd == nvm_prog_pkg::CMD_RD_FLASH);
    COV_FUSE_EXT: cover property (wr_fuse && pin.bs2);
endmodule : parallel_nvm_programming_port
`default_nettype wire

// ==== bench/prog_partner.sv ====
// programmer-side bus and external array model
`default_nettype none
module prog_partner (
    input wire logic clk_i, // core clock
    input wire logic oe_n_i, // programmer output enable
    input wire logic [7:0] pd_i, // programmer data
    input wire logic [7:0] dd_i, // device data
    input wire logic doe_n_i, // device drive, low drives
    input wire logic we_i, // array write
    input wire logic ee_i, // eeprom target
    input wire logic [13:0] a_i, // array address
    input wire logic [15:0] wd_i, // write data
    input wire logic er_i, // flash erase
    input wire logic er_ee_i, // eeprom erase
    output logic [7:0] bus_o, // bus level
    output logic [15:0] rd_o // array read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] fm [0:16383];
    logic [15:0] em [0:16383];
    // a released bus shows the inverse of the last value, not a held copy
    assign bus_o = !doe_n_i ? dd_i : (oe_n_i ? pd_i : ~dd_i);
    assign rd_o = ee_i ? em[a_i] : fm[a_i];
    always @(posedge clk_i) begin
        if (we_i && ee_i) begin
            em[a_i] <= wd_i;
        end else if (we_i) begin
            fm[a_i] <= wd_i;
        end
        for (int i = 0; i < ((er_i || er_ee_i) ? 16384 : 0); i++) begin
            if (er_i) begin
                fm[i] <= 16'hffff;
            end
            if (er_ee_i) begin
                em[i] <= 16'hffff;
            end
        end
    end
endmodule : prog_partner
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the programming port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    nvm_prog_pkg::pins_t p = nvm_prog_pkg::PINS_IDLE;
    logic [7:0] dout, bus, trim, fx, fh, fl, lock;
    logic doe_n, rdy, mode, we, ee, er, er_ee;
    logic [13:0] a, last_a;
    logic [15:0] wd, rd;
    int n_errors = 0;
    int n_checks = 0;
    int n_we, n_er, n_ee;
    parallel_nvm_programming_port #(.WRITE_CYCLES(16'h0004), .ERASE_CYCLES(16'h0008)) uut (
        .core_clk_i(clk), .rstn_i(rstn), .hv_reset_i(p.hv), .load_strobe_i(p.ld),
        .wr_n_i(p.wr_n), .oe_n_i(p.oe_n), .byte_select_lo_hi_i(p.bs1), .byte_select_ext_i(p.bs2),
        .strobe_action_bit0_i(p.xa0), .strobe_action_bit1_i(p.xa1), .page_buffer_latch_i(p.page_buffer_latch),
        .data_i(bus), .nvm_rdata_i(rd), .data_o(dout), .data_oe_n_o(doe_n), .ready_busy_n_o(rdy),
        .prog_mode_o(mode), .osc_trim_register_o(trim), .fuse_ext_o(fx), .fuse_high_o(fh),
        .fuse_low_o(fl), .lock_o(lock), .nvm_we_o(we), .nvm_ee_o(ee), .nvm_addr_o(a),
        .nvm_wdata_o(wd), .nvm_erase_o(er), .nvm_erase_ee_o(er_ee));
    prog_partner far (.clk_i(clk), .oe_n_i(p.oe_n), .pd_i(p.data), .dd_i(dout), .doe_n_i(doe_n),
        .we_i(we), .ee_i(ee), .a_i(a), .wd_i(wd), .er_i(er), .er_ee_i(er_ee), .bus_o(bus), .rd_o(rd));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(negedge clk) begin
        n_we += int'(we === 1'b1);
        n_er += int'(er === 1'b1);
        n_ee += int'(er_ee === 1'b1);
        if (we === 1'b1) begin
            last_a = a;
        end
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic step();
        repeat (4) @(posedge clk);
    endtask : step
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        p.xa1 <= act[1];
        p.xa0 <= act[0];
        p.bs1 <= bs1;
        p.data <= d;
        step();
        p.ld <= 1'b1;
        step();
        p.ld <= 1'b0;
        step();
    endtask : load
    task automatic latch();
        p.page_buffer_latch <= 1'b1;
        step();
        p.page_buffer_latch <= 1'b0;
        step();
    endtask : latch
    task automatic run_wr(input logic busy);
        int k;
        n_we = 0;
        n_er = 0;
        n_ee = 0;
        p.wr_n <= 1'b0;
        step();
        p.wr_n <= 1'b1;
        @(negedge clk);
        check("ready_busy_n", rdy, !busy);
        for (k = 0; k < 2000 && rdy !== 1'b1; k++) begin
            @(negedge clk);
        end
        check("ready after op", rdy, 1'b1);
        @(posedge clk);
    endtask : run_wr
    task automatic read(input logic bs2, input logic bs1, input logic [7:0] exp, input string nm);
        p.bs2 <= bs2;
        p.bs1 <= bs1;
        p.oe_n <= 1'b0;
        step();
        @(negedge clk);
        check(nm, bus, exp);
        check("data_oe_n drive", doe_n, 1'b0);
        @(posedge clk);
        p.oe_n <= 1'b1;
        step();
        @(negedge clk);
        check("data_oe_n release", doe_n, 1'b1);
        @(posedge clk);
    endtask : read
    task automatic fwrite(input logic [7:0] d, input logic bs2, input logic bs1);
        load(2'h1, 1'b0, d);
        p.bs2 <= bs2;
        p.bs1 <= bs1;
        step();
        run_wr(1'b1);
    endtask : fwrite
    task automatic t_sig();
        logic [7:0] sig [3];
        sig = '{nvm_prog_pkg::SIG_BYTE0, nvm_prog_pkg::SIG_BYTE1, nvm_prog_pkg::SIG_BYTE2};
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_RD_SIG);
        load(2'h0, 1'b1, 8'h00);
        for (int i = 0; i < 3; i++) begin
            load(2'h0, 1'b0, 8'(i));
            read(1'b0, 1'b0, sig[i], "signature");
        end
        load(2'h3, 1'b0, 8'h00);
        read(1'b0, 1'b0, sig[2], "idle action");
        load(2'h0, 1'b0, 8'h00);
        read(1'b0, 1'b1, nvm_prog_pkg::CAL_BYTE, "calibration");
    endtask : t_sig
    task automatic t_flash();
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_WR_FLASH);
        load(2'h0, 1'b0, 8'h7f);
        load(2'h1, 1'b0, 8'h5a);
        load(2'h1, 1'b1, 8'ha5);
        latch();
        load(2'h0, 1'b1, 8'h01);
        run_wr(1'b1);
        check("flash words", n_we, 64);
        check("flash last addr", last_a, 14'h017f);
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_RD_FLASH);
        read(1'b0, 1'b0, 8'h5a, "flash lo");
        read(1'b0, 1'b1, 8'ha5, "flash hi");
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_NOP);
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_WR_FLASH);
        run_wr(1'b0);
        check("write after nop", n_we, 0);
    endtask : t_flash
    task automatic t_ee();
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_WR_EE);
        load(2'h0, 1'b1, 8'h00);
        load(2'h0, 1'b0, 8'h06);
        load(2'h1, 1'b0, 8'h3c);
        latch();
        run_wr(1'b1);
        check("ee bytes", n_we, 4);
        check("ee last addr", last_a, 14'h0007);
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_RD_EE);
        read(1'b0, 1'b0, 8'h3c, "ee read");
    endtask : t_ee
    task automatic t_fuse();
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_WR_FUSE);
        fwrite(8'h7e, 1'b1, 1'b0);
        check("fuse ext", fx, 8'h7e);
        fwrite(8'ha5, 1'b0, 1'b1);
        check("fuse high", fh, 8'ha5);
        fwrite(8'h12, 1'b0, 1'b0);
        check("fuse low", fl, 8'h12);
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_WR_LOCK);
        fwrite(8'hfc, 1'b0, 1'b0);
        fwrite(8'hf3, 1'b0, 1'b0);
        check("lock", lock, 8'hf0);
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_RD_FUSE);
        read(1'b0, 1'b0, 8'h12, "rd fuse low");
        read(1'b1, 1'b0, 8'h7e, "rd fuse ext");
        read(1'b1, 1'b1, 8'ha5, "rd fuse high");
        read(1'b0, 1'b1, 8'hf0, "rd lock");
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_RD_SIG);
        read(1'b0, 1'b0, nvm_prog_pkg::SIG_BYTE2, "sig while locked");
    endtask : t_fuse
    task automatic t_erase();
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_ERASE);
        run_wr(1'b1);
        check("erase pulses", n_er, 1);
        check("ee kept", n_ee, 0);
        check("lock erased", lock, 8'hff);
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_RD_FLASH);
        read(1'b0, 1'b1, 8'hff, "erased flash");
        load(2'h2, 1'b0, nvm_prog_pkg::CMD_RD_EE);
        read(1'b0, 1'b0, 8'h3c, "ee kept data");
    endtask : t_erase
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (60000) @(posedge clk); // tests need about 39500 cycles
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check("trim", trim, nvm_prog_pkg::CAL_BYTE);
        check("mode idle", mode, 1'b0);
        @(posedge clk);
        p.hv <= 1'b1; // entry pins held at 0000
        repeat (1250) @(posedge clk); // entry pins held 10 us
        repeat (37500) @(posedge clk); // 300 us before commands
        check("mode", mode, 1'b1);
        t_sig();
        t_flash();
        t_ee();
        t_fuse();
        t_erase();
        p.hv <= 1'b0;
        step();
        check("mode exit", mode, 1'b0);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
